// >>> hdl/ufb_usart.sv
// Purpose: Serial transceiver with frame formatting and fractional baud generator.
// Assumes: All pin inputs are synchronous to clk; registers over AXI4-Lite.
// Notes: Two-entry buffers on both paths; status bits drive request outputs, except that data-empty also needs TX enabled.
`timescale 1ns/1ps
`default_nettype none

module ufb_usart (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic rxPin,
    input wire logic txPinIn,
    output logic txOut,
    output logic txOe,
    input wire logic transferClockPinIn,
    output logic transferClockPinOut,
    output logic transferClockPinOe,
    output logic lineDriverDirectionOut,
    output logic pinPullupEnable,
    output logic txCompleteReq,
    output logic dataEmptyReq,
    output logic rxCompleteReq
);
    ufb_pkg::ufb_state_t s;
    ufb_pkg::ufb_state_t next_s;
    ufb_pkg::ufb_rxent_t ent;
    logic sync, ext, active, bTick, tick, rxRaw, rxV, wrGo, rdGo, mid, last, rxPop;
    logic [4:0] spb;
    logic [3:0] nbits;
    logic [15:0] lim;
    logic [16:0] accSum;
    logic [8:0] rxData;

    function automatic logic [4:0] spbOf(input logic sy, input logic dbl);
        if (sy) begin
            return ufb_pkg::SPB_SYNC;
        end
        return dbl ? ufb_pkg::SPB_DBL : ufb_pkg::SPB_NORM;
    endfunction : spbOf

    function automatic logic [8:0] maskOf(input logic [8:0] d, input logic [3:0] nb);
        return d & 9'((10'h001 << nb) - 10'h001);
    endfunction : maskOf

    function automatic logic parOf(input logic [8:0] d, input logic [1:0] mode);
        return (^d) ^ (mode == ufb_pkg::PAR_ODD);
    endfunction : parOf

    assign sync = s.frame[ufb_pkg::FR_SYNC];
    assign ext = s.frame[ufb_pkg::FR_EXTCLK];
    assign active = s.enab[ufb_pkg::EN_TX] || s.enab[ufb_pkg::EN_RX] ||
        s.txState != ufb_pkg::TX_IDLE || s.txCnt != 2'h0;
    assign spb = spbOf(sync, s.enab[ufb_pkg::EN_DBL]);
    assign nbits = (s.frame[2:0] > 3'h4) ? ufb_pkg::MAX_BITS :
        ufb_pkg::MIN_BITS + 4'(s.frame[2:0]);
    // In synchronous mode the fraction is masked, so only the integer part counts.
    assign lim = sync ? {s.baud[15:6], 6'h00} : s.baud;
    assign accSum = s.acc + ufb_pkg::BAUD_STEP;
    // Sample ticks come at 64*f/divisor, so a bit of S ticks runs at 64*f/(S*divisor).
    assign bTick = active && !ext && (accSum >= {1'b0, lim});
    assign tick = ext ? (s.xckPrev != transferClockPinIn) : bTick;
    assign rxRaw = s.loop ? txPinIn : rxPin;
    assign rxV = sync ? rxRaw : ((s.filt[0] & s.filt[1]) | (s.filt[0] & s.filt[2]) |
        (s.filt[1] & s.filt[2]));
    assign mid = s.rxTick == (spb >> 1);
    assign last = s.rxTick == spb - 5'h01;
    assign awready = !s.awHeld && !s.bvalid;
    assign wready = !s.wHeld && !s.bvalid;
    assign arready = !s.rvalid;
    assign wrGo = s.awHeld && s.wHeld && !s.bvalid;
    assign rdGo = arvalid && arready;
    assign rxPop = rdGo && araddr == ufb_pkg::OFF_RXDATA && s.rxCnt != 2'h0;
    assign rxData = 9'(s.rxShift >> (4'h9 - nbits));
    always_comb begin
        ent = '0;
        ent.data = rxData;
        ent.ferr = !rxV;
        ent.perr = s.frame[4] && (s.rxPar != parOf(rxData, s.frame[4:3]));
    end

    always_comb begin
        next_s = s;
        next_s.xckPrev = transferClockPinIn;
        if (!active) begin
            next_s.acc = '0;
        end else if (bTick) begin
            next_s.acc = accSum - {1'b0, lim};
        end else if (!ext) begin
            next_s.acc = accSum;
        end
        if (bTick && sync) begin
            next_s.xckOut = !s.xckOut;
        end
        if (awvalid && awready) begin
            next_s.awHeld = 1'b1;
            next_s.awAddr = awaddr;
        end
        if (wvalid && wready) begin
            next_s.wHeld = 1'b1;
            next_s.wData = wdata;
            next_s.wStrb = wstrb;
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (wrGo) begin
            next_s.awHeld = 1'b0;
            next_s.wHeld = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = ufb_pkg::RESP_OK;
            unique case (s.awAddr)
                ufb_pkg::OFF_FEATURE_CONTROL: begin
                    if (s.wStrb[0]) begin
                        next_s.loop = s.wData[ufb_pkg::FE_LOOP];
                    end
                end
                ufb_pkg::OFF_TX_RX_ENABLE_CONTROL: begin
                    if (s.wStrb[0]) begin
                        next_s.enab = s.wData[3:0];
                    end
                end
                ufb_pkg::OFF_FRAME_FORMAT_CONTROL: begin
                    if (s.wStrb[0]) begin
                        next_s.frame = s.wData[7:0];
                    end
                end
                ufb_pkg::OFF_BAUD: begin
                    // Restarting the accumulator keeps it below any new divisor.
                    next_s.acc = '0;
                    if (s.wStrb[0]) begin
                        next_s.baud[7:0] = s.wData[7:0];
                    end
                    if (s.wStrb[1]) begin
                        next_s.baud[15:8] = s.wData[15:8];
                    end
                end
                ufb_pkg::OFF_STATUS: begin
                    if (s.wStrb[0] && s.wData[ufb_pkg::ST_TXC]) begin
                        next_s.txc = 1'b0;
                    end
                end
                ufb_pkg::OFF_TXDATA: begin
                end
                default: next_s.bresp = ufb_pkg::RESP_SLVERR;
            endcase
        end
        // Transmitter: a bit lasts S ticks; the buffer drains even after disable.
        unique case (s.txState)
            ufb_pkg::TX_IDLE: begin
            end
            default: begin
                if (tick) begin
                    next_s.txTick = s.txTick + 5'h01;
                    if (s.txTick == spb - 5'h01) begin
                        next_s.txTick = '0;
                        unique case (s.txState)
                            ufb_pkg::TX_START: begin
                                next_s.txState = ufb_pkg::TX_DATA;
                                next_s.txBit = '0;
                            end
                            ufb_pkg::TX_DATA: begin
                                next_s.txShift = {1'b0, s.txShift[8:1]};
                                next_s.txBit = s.txBit + 4'h1;
                                if (s.txBit == nbits - 4'h1) begin
                                    next_s.txState = s.frame[4] ? ufb_pkg::TX_PAR :
                                        ufb_pkg::TX_STOP;
                                    next_s.txStopN = 1'b0;
                                end
                            end
                            ufb_pkg::TX_PAR: begin
                                next_s.txState = ufb_pkg::TX_STOP;
                                next_s.txStopN = 1'b0;
                            end
                            default: begin
                                if (s.frame[ufb_pkg::FR_STOP2] && !s.txStopN) begin
                                    next_s.txStopN = 1'b1;
                                end else begin
                                    next_s.txState = ufb_pkg::TX_IDLE;
                                    if (s.txCnt == 2'h0) begin
                                        next_s.txc = 1'b1;
                                    end
                                end
                            end
                        endcase
                    end
                end
            end
        endcase
        if (next_s.txState == ufb_pkg::TX_IDLE && s.txCnt != 2'h0) begin
            next_s.txState = ufb_pkg::TX_START;
            next_s.txTick = '0;
            next_s.txShift = maskOf(s.txBuf[0], nbits);
            next_s.txPar = parOf(maskOf(s.txBuf[0], nbits), s.frame[4:3]);
            next_s.txBuf[0] = s.txBuf[1];
            next_s.txCnt = s.txCnt - 2'h1;
        end
        if (wrGo && s.awAddr == ufb_pkg::OFF_TXDATA && s.enab[ufb_pkg::EN_TX] &&
                s.txCnt != ufb_pkg::BUF_DEPTH) begin
            next_s.txBuf[next_s.txCnt[0]] = s.wData[8:0];
            next_s.txCnt = next_s.txCnt + 2'h1;
        end
        unique case (next_s.txState)
            ufb_pkg::TX_START: next_s.txLine = 1'b0;
            ufb_pkg::TX_DATA: next_s.txLine = next_s.txShift[0];
            ufb_pkg::TX_PAR: next_s.txLine = next_s.txPar;
            default: next_s.txLine = 1'b1;
        endcase
        // Receiver: majority of three ticks outside synchronous mode, mid-bit sampling, start re-checked.
        if (tick) begin
            next_s.filt = {s.filt[1:0], rxRaw};
        end
        if (rxPop) begin
            next_s.rxBuf[0] = s.rxBuf[1];
            next_s.rxBuf[1] = '0;
            next_s.rxCnt = s.rxCnt - 2'h1;
        end
        if (tick) begin
            next_s.rxTick = s.rxTick + 5'h01;
            unique case (s.rxState)
                ufb_pkg::RX_IDLE: begin
                    next_s.rxTick = 5'h01;
                    if (!rxV) begin
                        next_s.rxState = ufb_pkg::RX_START;
                    end
                end
                ufb_pkg::RX_START: begin
                    if (mid && rxV) begin
                        next_s.rxState = ufb_pkg::RX_IDLE;
                    end else if (last) begin
                        next_s.rxState = ufb_pkg::RX_DATA;
                        next_s.rxTick = '0;
                        next_s.rxBit = '0;
                    end
                end
                ufb_pkg::RX_DATA: begin
                    if (mid) begin
                        next_s.rxShift = {rxV, s.rxShift[8:1]};
                    end
                    if (last) begin
                        next_s.rxTick = '0;
                        next_s.rxBit = s.rxBit + 4'h1;
                        if (s.rxBit == nbits - 4'h1) begin
                            next_s.rxState = s.frame[4] ? ufb_pkg::RX_PAR :
                                ufb_pkg::RX_STOP;
                        end
                    end
                end
                ufb_pkg::RX_PAR: begin
                    if (mid) begin
                        next_s.rxPar = rxV;
                    end
                    if (last) begin
                        next_s.rxTick = '0;
                        next_s.rxState = ufb_pkg::RX_STOP;
                    end
                end
                default: begin
                    if (mid) begin
                        next_s.rxState = ufb_pkg::RX_IDLE;
                        if (next_s.rxCnt == ufb_pkg::BUF_DEPTH) begin
                            next_s.rxBuf[1] = ent;
                            next_s.rxBuf[1].ovf = 1'b1;
                        end else begin
                            next_s.rxBuf[next_s.rxCnt[0]] = ent;
                            next_s.rxCnt = next_s.rxCnt + 2'h1;
                        end
                    end
                end
            endcase
        end
        if (!s.enab[ufb_pkg::EN_RX]) begin
            next_s.rxState = ufb_pkg::RX_IDLE;
            next_s.rxCnt = '0;
            next_s.rxBuf = '0;
        end
        if (rdGo) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = ufb_pkg::RESP_OK;
            next_s.rdata = '0;
            unique case (araddr)
                ufb_pkg::OFF_FEATURE_CONTROL: next_s.rdata[0] = s.loop;
                ufb_pkg::OFF_TX_RX_ENABLE_CONTROL: next_s.rdata[3:0] = s.enab;
                ufb_pkg::OFF_FRAME_FORMAT_CONTROL: next_s.rdata[7:0] = s.frame;
                ufb_pkg::OFF_BAUD: next_s.rdata[15:0] = s.baud;
                ufb_pkg::OFF_STATUS: begin
                    next_s.rdata[ufb_pkg::ST_TXC] = s.txc;
                    next_s.rdata[ufb_pkg::ST_DRE] = s.txCnt != ufb_pkg::BUF_DEPTH;
                    next_s.rdata[ufb_pkg::ST_RXC] = s.rxCnt != 2'h0;
                end
                ufb_pkg::OFF_RXDATA: next_s.rdata[11:0] = s.rxBuf[0];
                default: next_s.rresp = ufb_pkg::RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.baud <= ufb_pkg::BAUD_RST;
            s.frame <= ufb_pkg::FRAME_RST;
            s.txState <= ufb_pkg::TX_IDLE;
            s.rxState <= ufb_pkg::RX_IDLE;
            s.txLine <= 1'b1;
            s.filt <= 3'h7;
        end else if (clkEn) begin
            s <= next_s;
        end
    end

    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    // Open drain only ever pulls low, which also claims the pin as an output.
    assign txOut = s.enab[ufb_pkg::EN_OPEN_DRAIN_ENABLE] ? 1'b0 : s.txLine;
    assign txOe = s.enab[ufb_pkg::EN_OPEN_DRAIN_ENABLE] ? !s.txLine :
        (s.enab[ufb_pkg::EN_TX] || s.txState != ufb_pkg::TX_IDLE);
    assign transferClockPinOut = s.xckOut;
    assign transferClockPinOe = sync && !ext;
    assign lineDriverDirectionOut = s.txState != ufb_pkg::TX_IDLE;
    assign pinPullupEnable = s.enab[ufb_pkg::EN_OPEN_DRAIN_ENABLE];
    assign txCompleteReq = s.txc;
    assign dataEmptyReq = s.enab[ufb_pkg::EN_TX] && s.txCnt != ufb_pkg::BUF_DEPTH;
    assign rxCompleteReq = s.rxCnt != 2'h0;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    property p_start;
        $rose(s.txState == ufb_pkg::TX_START) |-> !s.txLine;
    endproperty
    a_start: assert property (p_start) else $error("start bit not low");
    property p_stop;
        s.txState == ufb_pkg::TX_STOP |-> s.txLine;
    endproperty
    a_stop: assert property (p_stop) else $error("stop bit not high");
    property p_idle;
        s.txState == ufb_pkg::TX_IDLE |-> s.txLine && !lineDriverDirectionOut;
    endproperty
    a_idle: assert property (p_idle) else $error("idle line not high");
    property p_txbuf;
        s.txCnt <= ufb_pkg::BUF_DEPTH;
    endproperty
    a_txbuf: assert property (p_txbuf) else $error("tx buffer overfilled");
    property p_rxbuf;
        s.rxCnt <= ufb_pkg::BUF_DEPTH;
    endproperty
    a_rxbuf: assert property (p_rxbuf) else $error("rx buffer overfilled");
    property p_spb;
        s.txState != ufb_pkg::TX_IDLE |-> s.txTick < spb;
    endproperty
    a_spb: assert property (p_spb) else $error("bit longer than S ticks");
    property p_frac;
        s.baud >= 16'h0040 && $stable(s.baud) && !sync |=> s.acc < {1'b0, s.baud};
    endproperty
    a_frac: assert property (p_frac) else $error("accumulator beyond divisor");
    property p_dir;
        $fell(lineDriverDirectionOut) |-> $past(s.txState) == ufb_pkg::TX_STOP;
    endproperty
    a_dir: assert property (p_dir) else $error("driver released before stop");
    property p_od;
        s.enab[ufb_pkg::EN_OPEN_DRAIN_ENABLE] |-> !txOut && (txOe == !s.txLine);
    endproperty
    a_od: assert property (p_od) else $error("open drain drives high");
    property p_loop;
        s.loop && tick && clkEn |=> s.filt[0] == $past(txPinIn);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback not sampled");
    c_b2b: cover property (s.txState == ufb_pkg::TX_STOP ##1 s.txState == ufb_pkg::TX_START);
    c_ovf: cover property (s.rxBuf[1].ovf);
    c_false: cover property (s.rxState == ufb_pkg::RX_START ##1 s.rxState == ufb_pkg::RX_IDLE);
endmodule : ufb_usart

`default_nettype wire

// >>> hdl/ufb_pkg.sv
// Purpose: Shared constants and types of the serial frame and baud core.
// Assumes: 32-bit AXI4-Lite register access, one word per register.
// Notes: Offsets are byte addresses.
package ufb_pkg;
    localparam logic [7:0] OFF_FEATURE_CONTROL = 8'h00;
    localparam logic [7:0] OFF_TX_RX_ENABLE_CONTROL = 8'h04;
    localparam logic [7:0] OFF_FRAME_FORMAT_CONTROL = 8'h08;
    localparam logic [7:0] OFF_BAUD = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_TXDATA = 8'h14;
    localparam logic [7:0] OFF_RXDATA = 8'h18;
    localparam int FE_LOOP = 0;
    localparam int EN_TX = 0;
    localparam int EN_RX = 1;
    localparam int EN_OPEN_DRAIN_ENABLE = 2;
    localparam int EN_DBL = 3;
    localparam int FR_CHS = 0;
    localparam int FR_PAR = 3;
    localparam int FR_STOP2 = 5;
    localparam int FR_SYNC = 6;
    localparam int FR_EXTCLK = 7;
    localparam int ST_TXC = 0;
    localparam int ST_DRE = 1;
    localparam int ST_RXC = 2;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD = 2'h3;
    localparam logic [4:0] SPB_NORM = 5'h10;
    localparam logic [4:0] SPB_DBL = 5'h08;
    localparam logic [4:0] SPB_SYNC = 5'h02;
    localparam logic [16:0] BAUD_STEP = 17'h00040;
    localparam logic [3:0] MIN_BITS = 4'h5;
    localparam logic [3:0] MAX_BITS = 4'h9;
    localparam logic [1:0] BUF_DEPTH = 2'h2;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] BAUD_RST = 16'h0000;
    localparam logic [7:0] FRAME_RST = 8'h03;

    typedef enum logic [4:0] {TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
        TX_PAR = 5'h08, TX_STOP = 5'h10} ufb_tx_t;
    typedef enum logic [4:0] {RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
        RX_PAR = 5'h08, RX_STOP = 5'h10} ufb_rx_t;

    typedef struct packed {
        logic ovf;
        logic perr;
        logic ferr;
        logic [8:0] data;
    } ufb_rxent_t;

    typedef struct packed {
        logic loop;
        logic [3:0] enab;
        logic [7:0] frame;
        logic [15:0] baud;
        logic [16:0] acc;
        logic xckPrev;
        logic xckOut;
        ufb_tx_t txState;
        logic [4:0] txTick;
        logic [3:0] txBit;
        logic [8:0] txShift;
        logic txPar;
        logic txStopN;
        logic [1:0][8:0] txBuf;
        logic [1:0] txCnt;
        logic txc;
        logic txLine;
        ufb_rx_t rxState;
        logic [4:0] rxTick;
        logic [3:0] rxBit;
        logic [8:0] rxShift;
        logic rxPar;
        logic [2:0] filt;
        ufb_rxent_t [1:0] rxBuf;
        logic [1:0] rxCnt;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ufb_state_t;
endpackage : ufb_pkg

// >>> verif/ufb_remote.sv
// Purpose: Remote serial transceiver that checks frames and echoes them back.
// Assumes: Lines idle high; bitLen clock cycles per bit.
// Notes: badPar and badStop corrupt the echoed parity or stop bit.
`timescale 1ns/1ps
`default_nettype none
module ufb_remote (
    input wire logic clk,
    input wire logic line,
    input wire logic [7:0] bitLen,
    input wire logic [3:0] nBits,
    input wire logic [1:0] par,
    input wire logic stop2,
    input wire logic echoEn,
    input wire logic badPar,
    input wire logic badStop,
    output logic rxLine,
    output logic [8:0] got,
    output logic gotPar,
    output logic gotStop,
    output logic [7:0] seen,
    output logic [7:0] sent
);
    logic [8:0] q[$];
    task automatic bw(input logic [7:0] n);
        repeat (n) @(posedge clk);
    endtask : bw
    initial begin
        seen = 8'h00;
        forever begin
            @(negedge line);
            bw(bitLen / 2);
            if (!line) begin
                got = 9'h000;
                for (int i = 0; i < nBits; i++) begin
                    bw(bitLen);
                    got[i] = line;
                end
                if (par[1]) begin
                    bw(bitLen);
                    gotPar = line;
                end
                bw(bitLen);
                gotStop = line;
                if (stop2) begin
                    bw(bitLen);
                    gotStop = gotStop & line;
                end
                if (echoEn) q.push_back(got);
                seen = seen + 8'h01;
            end
        end
    end
    initial begin
        logic [8:0] d;
        rxLine = 1'b1;
        sent = 8'h00;
        forever begin
            @(posedge clk);
            if (q.size() > 0) begin
                d = q.pop_front();
                rxLine <= 1'b0;
                bw(bitLen);
                for (int i = 0; i < nBits; i++) begin
                    rxLine <= d[i];
                    bw(bitLen);
                end
                if (par[1]) begin
                    rxLine <= ^d ^ par[0] ^ badPar;
                    bw(bitLen);
                end
                rxLine <= !badStop;
                bw(stop2 ? bitLen * 2 : bitLen);
                rxLine <= 1'b1;
                sent = sent + 8'h01;
            end
        end
    end
endmodule : ufb_remote
`default_nettype wire

// >>> verif/ufb_usart_tb.sv
// Purpose: Self-checking bench for the serial frame and baud core.
// Assumes: The remote model echoes each frame it receives unless told not to.
// Notes: The wire level is the pull-up unless the core enables its driver.
`timescale 1ns/1ps
`default_nettype none
module ufb_usart_tb;
    logic clk = 1'b0;
    logic clkEn = 1'b1;
    logic transferClockPinIn = 1'b0;
    logic reset_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, rxPin, txPinIn, txOut, txOe, transferClockPinOut, transferClockPinOe;
    logic lineDriverDirectionOut, pinPullupEnable, txCompleteReq, dataEmptyReq, rxCompleteReq;
    logic [7:0] awaddr, araddr, bitLen, seen, sent, nf;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, nBits;
    logic [1:0] bresp, rresp, par;
    logic stop2, echoEn, badPar, badStop, gotPar, gotStop;
    logic xckRun = 1'b0;
    logic [8:0] got, m;
    int err_count = 0;
    int check_count = 0;
    assign txPinIn = txOe ? txOut : 1'b1;
    always #4 clk = ~clk;
    // The external transfer clock toggles only while its scenario runs.
    always @(posedge clk) begin
        if (xckRun) begin
            transferClockPinIn <= !transferClockPinIn;
        end
    end
    ufb_usart u_dut (.*);
    ufb_remote u_rem (.clk, .line(txPinIn), .bitLen, .nBits, .par, .stop2, .echoEn, .badPar,
        .badStop, .rxLine(rxPin), .got, .gotPar, .gotStop, .seen, .sent);
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 4000) begin
            err_count++;
            tally_and_finish();
        end
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        logic aw = 1'b1;
        logic w = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw || w) begin
            tick(n);
            if (aw && awready) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do tick(n); while (!bvalid);
        check(bresp, ufb_pkg::RESP_OK);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do tick(n); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do tick(n); while (!rvalid);
        rready <= 1'b0;
        check(rdata, d);
        check(rresp, r);
    endtask : rd
    task automatic rx(input logic [31:0] d);
        rd(ufb_pkg::OFF_RXDATA, d, ufb_pkg::RESP_OK);
    endtask : rx
    task automatic tx(input logic [31:0] d);
        wr(ufb_pkg::OFF_TXDATA, d);
        nf = nf + 8'h01;
        // The frame starts on the edge after the write response, so look one edge later.
        @(posedge clk);
    endtask : tx
    task automatic waitCnt(input logic useSeen);
        int n = 0;
        while ((useSeen ? seen : sent) < nf) tick(n);
    endtask : waitCnt
    task automatic setFmt(input logic [7:0] f);
        wr(ufb_pkg::OFF_FRAME_FORMAT_CONTROL, {24'h0, f});
        nBits <= (f[2:0] > 3'h4) ? 4'h9 : {1'b0, f[2:0]} + 4'h5;
        par <= f[4:3];
        stop2 <= f[5];
        @(posedge clk);
        m = (9'h001 << nBits) - 9'h001;
    endtask : setFmt
    initial begin
        logic [7:0] fmts [5] = '{8'h03, 8'h30, 8'h1c, 8'h39, 8'h12};
        logic [8:0] dats [5] = '{9'h05a, 9'h0f3, 9'h1a5, 9'h0ea, 9'h07f};
        int n;
        {reset_n, awvalid, wvalid, bready, arvalid, rready, stop2, badPar, badStop} = 9'h000;
        {awaddr, araddr, wdata, nf, par} = 58'h0;
        {wstrb, nBits, bitLen, echoEn} = {4'hf, 4'h8, 8'd8, 1'b1};
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        check(dataEmptyReq, 0);
        rd(ufb_pkg::OFF_FRAME_FORMAT_CONTROL, 32'h3, ufb_pkg::RESP_OK);
        rd(8'h1c, 32'h0, ufb_pkg::RESP_SLVERR);
        wr(ufb_pkg::OFF_BAUD, 32'h40);
        wr(ufb_pkg::OFF_TX_RX_ENABLE_CONTROL, 32'hb);
        check(dataEmptyReq, 1);
        for (int k = 0; k < 5; k++) begin
            setFmt(fmts[k]);
            tx({23'h0, dats[k]});
            check({txPinIn, lineDriverDirectionOut}, 2'b01);
            waitCnt(1'b1);
            check(got, dats[k] & m);
            if (par[1]) check(gotPar, ^(dats[k] & m) ^ par[0]);
            check(gotStop, 1);
            waitCnt(1'b0);
            check(txCompleteReq, 1);
            rx({23'h0, dats[k] & m});
        end
        setFmt(8'h03);
        for (int k = 1; k < 4; k++) begin
            n = 0;
            while (!dataEmptyReq) tick(n);
            tx(32'h11 * k);
        end
        waitCnt(1'b0);
        rx(32'h011);
        rx(32'h833);
        @(posedge clk);
        check(rxCompleteReq, 0);
        setFmt(8'h13);
        for (int e = 0; e < 2; e++) begin
            badPar <= (e == 0);
            badStop <= (e == 1);
            tx(32'h0c5);
            waitCnt(1'b0);
            rx(e ? 32'h2c5 : 32'h4c5);
        end
        {badPar, badStop} <= 2'b00;
        wr(ufb_pkg::OFF_BAUD, 32'h60);
        wr(ufb_pkg::OFF_TX_RX_ENABLE_CONTROL, 32'h3);
        bitLen <= 8'd24;
        tx(32'h0c3);
        waitCnt(1'b1);
        check(got, 9'h0c3);
        waitCnt(1'b0);
        rx(32'h0c3);
        wr(ufb_pkg::OFF_STATUS, 32'h1);
        check(txCompleteReq, 0);
        wr(ufb_pkg::OFF_FRAME_FORMAT_CONTROL, 32'h43);
        check(transferClockPinOe, 1);
        for (int k = 0; k < 3; k++) begin
            m[0] = transferClockPinOut;
            @(posedge clk);
            check(transferClockPinOut, !m[0]);
        end
        bitLen <= 8'd16;
        xckRun <= 1'b1;
        setFmt(8'h83);
        tx(32'h05a);
        waitCnt(1'b1);
        check(got, 9'h05a);
        waitCnt(1'b0);
        rx(32'h05a);
        xckRun <= 1'b0;
        bitLen <= 8'd24;
        setFmt(8'h03);
        echoEn <= 1'b0;
        wr(ufb_pkg::OFF_FEATURE_CONTROL, 32'h1);
        wr(ufb_pkg::OFF_TX_RX_ENABLE_CONTROL, 32'h7);
        check(pinPullupEnable, 1);
        tx(32'h096);
        check({txOe, txOut}, 2'b10);
        waitCnt(1'b1);
        n = 0;
        while (!rxCompleteReq) tick(n);
        rx(32'h096);
        tally_and_finish();
    end
endmodule : ufb_usart_tb
`default_nettype wire
